// ==== tesq_pkg.sv ====
// Shared constants for the 16-bit timer with event, square wave and one-shot functions
package tesq_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFF_MAIN_COUNTER   = 5'h00;
  localparam logic [4:0] OFF_PERIOD_COMPARE = 5'h04;
  localparam logic [4:0] OFF_PULSE_COMPARE  = 5'h08;
  localparam logic [4:0] OFF_PRESCALER_MODE = 5'h0c;
  localparam logic [4:0] OFF_TIMER_MODE     = 5'h10;
  localparam logic [4:0] OFF_OUTPUT_CONTROL = 5'h14;
  localparam logic [4:0] OFF_CAPTURE_CTRL   = 5'h18;
  localparam logic [4:0] OFF_STATUS         = 5'h1c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PRM_CLKSEL_LSB   = 0;  // Count clock select, 2 bits
  localparam int PRM_EDGE_LO_BIT  = 4;  // event_edge_sel_lo
  localparam int PRM_EDGE_HI_BIT  = 5;  // event_edge_sel_hi
  localparam int TMC_RUN_A_BIT    = 2;  // run_mode_bit_a
  localparam int TMC_RUN_B_BIT    = 3;  // run_mode_bit_b
  localparam int TOC_OE_BIT       = 0;  // output_enable_bit
  localparam int TOC_TOGGLE_BIT   = 1;  // toggle_on_match_bit
  localparam int TOC_ONESHOT_BIT  = 4;  // One-shot output mode
  localparam int TOC_SWTRIG_BIT   = 6;  // software_oneshot_trigger, write-only
  localparam int CRC_CAPTURE_BIT  = 0;  // pulse_compare_reg acts as capture register
  localparam int STA_OUT_BIT      = 0;
  localparam int STA_ACTIVE_BIT   = 1;
  localparam int STA_LEVEL_BIT    = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_PERIOD  = 16'hffff;
  localparam logic [15:0] RST_PULSE   = 16'h0000;
  localparam logic [7:0]  RST_PRM     = 8'h00;
  localparam logic [7:0]  RST_TMC     = 8'h00;
  localparam logic [7:0]  RST_TOC     = 8'h00;
  localparam logic [7:0]  RST_CRC     = 8'h00;

  // ------------------------------------------------------------
  // Run modes, count clock sources and edge selections
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TESQ_RUN_STOP      = 2'b00,
    TESQ_RUN_FREE      = 2'b01,
    TESQ_RUN_EDGE_CLR  = 2'b10,
    TESQ_RUN_MATCH_CLR = 2'b11
  } tesq_run_t;

  typedef enum logic [1:0] {
    TESQ_CLK_DIV2  = 2'b00,
    TESQ_CLK_DIV4  = 2'b01,
    TESQ_CLK_DIV8  = 2'b10,
    TESQ_CLK_EVENT = 2'b11
  } tesq_clksel_t;

  typedef enum logic [1:0] {
    TESQ_EDGE_FALL = 2'b00,
    TESQ_EDGE_RISE = 2'b01,
    TESQ_EDGE_NONE = 2'b10,
    TESQ_EDGE_BOTH = 2'b11
  } tesq_edge_t;

  // Trigger sampling divides the base clock by this count
  localparam int          SAMPLE_DIV   = 2;
  localparam logic [2:0]  PRESC_RST    = 3'h0;
  localparam logic [31:0] RDATA_UNMAP  = 32'h0000_0000;

endpackage

// ==== tesq_timer.sv ====
// 16-bit timer/event counter with square wave and one-shot pulse output
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module tesq_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trigger_input_pin,
  output logic             timer_output_pin,
  output logic             period_match_irq,
  output logic             capture_pulse_irq
);
  import tesq_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  tesq_trig_if trig ();

  logic        busAck;
  logic [31:0] readData;
  logic        next_busAck;
  logic [31:0] next_readData;
  logic        wrEn;

  logic [15:0] main_counter;
  logic [15:0] period_compare_reg;
  logic [15:0] pulse_compare_reg;
  logic [7:0]  prescaler_mode_reg;
  logic [7:0]  timer_mode_reg;
  logic [7:0]  output_control_reg;
  logic [7:0]  capture_compare_ctrl_reg;
  logic [15:0] next_period;
  logic [15:0] next_pulse;
  logic [7:0]  next_prm;
  logic [7:0]  next_tmc;
  logic [7:0]  next_toc;
  logic [7:0]  next_crc;

  logic [2:0]  presc;
  logic        halfPhase;
  logic [15:0] next_counter;
  logic [2:0]  next_presc;
  logic        next_halfPhase;

  logic        outLevel;
  logic        pulseActive;
  logic        periodIrq;
  logic        next_outLevel;
  logic        next_pulseActive;
  logic        next_periodIrq;

  logic        capPending;
  logic        capIrqPending;
  logic        capIrq;
  logic        next_capPending;
  logic        next_capIrqPending;
  logic        next_capIrq;

  tesq_run_t    runMode;
  tesq_clksel_t clkSel;
  logic         running;
  logic         countTick;
  logic         periodMatch;
  logic         pulseMatch;
  logic         swTrigger;
  logic         oneShotMode;
  logic         extTrigger;
  logic         clearStart;
  logic         toggleMode;
  logic         captureMode;

  // ------------------------------------------------------------
  // Trigger filter
  // ------------------------------------------------------------
  tesq_trig_filter u_trig_filter (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .trigIn  (trigger_input_pin),
    .trig    (trig)
  );

  // Edge select and sampling strobe into the filter
  assign trig.edgeSel  = tesq_edge_t'({prescaler_mode_reg[PRM_EDGE_HI_BIT],
                                       prescaler_mode_reg[PRM_EDGE_LO_BIT]});
  assign trig.sampleEn = halfPhase;
  assign trig.accept   = running;   // Stopped timer accepts no pin edges

  // ------------------------------------------------------------
  // Decoded control
  // ------------------------------------------------------------
  assign runMode     = tesq_run_t'({timer_mode_reg[TMC_RUN_B_BIT],
                                    timer_mode_reg[TMC_RUN_A_BIT]});
  assign running     = (runMode != TESQ_RUN_STOP);
  assign clkSel      = tesq_clksel_t'(prescaler_mode_reg[PRM_CLKSEL_LSB +: 2]);
  assign oneShotMode = output_control_reg[TOC_ONESHOT_BIT];
  assign toggleMode  = output_control_reg[TOC_OE_BIT] && output_control_reg[TOC_TOGGLE_BIT];
  assign captureMode = capture_compare_ctrl_reg[CRC_CAPTURE_BIT];
  assign wrEn        = avs_write && busAck && ce;

  // Count clock: free-running prescaler, or filtered pin edges in event mode.
  // The prescaler is never restarted, so the first period after start is off
  // by up to one count clock; cheaper than re-phasing on every start.
  always_comb begin
    unique case (clkSel)
      TESQ_CLK_DIV2:  countTick = (presc[0] == 1'b1);
      TESQ_CLK_DIV4:  countTick = (presc[1:0] == 2'b11);
      TESQ_CLK_DIV8:  countTick = (presc == 3'b111);
      TESQ_CLK_EVENT: countTick = trig.validEdge;
    endcase
    countTick = countTick && running && ce;
  end

  // Matches are judged on the count clock against the held counter value
  assign periodMatch = countTick && (main_counter == period_compare_reg);
  assign pulseMatch  = countTick && (main_counter == pulse_compare_reg);

  // Software trigger is a write-one strobe, never stored
  assign swTrigger = wrEn && (avs_address == OFF_OUTPUT_CONTROL) && avs_byteenable[0]
                     && avs_writedata[TOC_SWTRIG_BIT] && running;

  // External trigger only in edge-restart mode, and never mid-pulse
  assign extTrigger = (runMode == TESQ_RUN_EDGE_CLR) && trig.validEdge
                      && !(oneShotMode && pulseActive);

  assign clearStart = swTrigger || extTrigger;

  // ------------------------------------------------------------
  // Avalon slave: one wait state per access
  // ------------------------------------------------------------
  // Read data is captured in the wait cycle and stands at the release edge
  always_comb begin
    next_busAck   = (avs_read || avs_write) && !busAck;
    next_readData = readData;
    if (avs_read && !busAck) begin
      unique case (avs_address)
        OFF_MAIN_COUNTER:   next_readData = {16'h0000, main_counter};
        OFF_PERIOD_COMPARE: next_readData = {16'h0000, period_compare_reg};
        OFF_PULSE_COMPARE:  next_readData = {16'h0000, pulse_compare_reg};
        OFF_PRESCALER_MODE: next_readData = {24'h000000, prescaler_mode_reg};
        OFF_TIMER_MODE:     next_readData = {24'h000000, timer_mode_reg};
        OFF_OUTPUT_CONTROL: next_readData = {24'h000000, output_control_reg};
        OFF_CAPTURE_CTRL:   next_readData = {24'h000000, capture_compare_ctrl_reg};
        OFF_STATUS: begin
          next_readData                = RDATA_UNMAP;
          next_readData[STA_OUT_BIT]   = outLevel;
          next_readData[STA_ACTIVE_BIT] = pulseActive;
          next_readData[STA_LEVEL_BIT] = trig.level;
        end
        default:            next_readData = RDATA_UNMAP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busAck   <= 1'b0;
      readData <= RDATA_UNMAP;
    end else if (ce) begin
      busAck   <= next_busAck;
      readData <= next_readData;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !busAck;
  assign avs_readdata    = readData;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Byte lanes 0 and 1 cover the 16-bit fields; upper lanes are ignored.
  // A captured count overrides a software write in the same cycle.
  always_comb begin
    next_period = period_compare_reg;
    next_pulse  = pulse_compare_reg;
    next_prm    = prescaler_mode_reg;
    next_tmc    = timer_mode_reg;
    next_toc    = output_control_reg;
    next_crc    = capture_compare_ctrl_reg;
    if (wrEn && avs_byteenable[0]) begin
      unique case (avs_address)
        OFF_PERIOD_COMPARE: next_period[7:0] = avs_writedata[7:0];
        OFF_PULSE_COMPARE:  next_pulse[7:0]  = avs_writedata[7:0];
        OFF_PRESCALER_MODE: next_prm         = avs_writedata[7:0];
        OFF_TIMER_MODE:     next_tmc         = avs_writedata[7:0];
        OFF_OUTPUT_CONTROL: next_toc         = avs_writedata[7:0] & 8'hbf;
        OFF_CAPTURE_CTRL:   next_crc         = avs_writedata[7:0];
        default:            next_tmc         = timer_mode_reg;
      endcase
    end
    if (wrEn && avs_byteenable[1]) begin
      if (avs_address == OFF_PERIOD_COMPARE) begin
        next_period[15:8] = avs_writedata[15:8];
      end
      if (avs_address == OFF_PULSE_COMPARE) begin
        next_pulse[15:8] = avs_writedata[15:8];
      end
    end
    if (captureMode && countTick && (capPending || trig.validEdge)) begin
      next_pulse = main_counter;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      period_compare_reg       <= RST_PERIOD;
      pulse_compare_reg        <= RST_PULSE;
      prescaler_mode_reg       <= RST_PRM;
      timer_mode_reg           <= RST_TMC;
      output_control_reg       <= RST_TOC;
      capture_compare_ctrl_reg <= RST_CRC;
    end else if (ce) begin
      period_compare_reg       <= next_period;
      pulse_compare_reg        <= next_pulse;
      prescaler_mode_reg       <= next_prm;
      timer_mode_reg           <= next_tmc;
      output_control_reg       <= next_toc;
      capture_compare_ctrl_reg <= next_crc;
    end
  end

  // ------------------------------------------------------------
  // Prescaler and main counter
  // ------------------------------------------------------------
  // Counter clears only on equality, so a period lowered below the count
  // runs on through 16'hffff and wraps before the next match
  always_comb begin
    next_presc     = presc + 3'h1;
    next_halfPhase = (SAMPLE_DIV == 2) ? !halfPhase : 1'b1;
    next_counter   = main_counter;
    if (!running) begin
      next_counter = RST_COUNTER;
    end else if (clearStart) begin
      next_counter = RST_COUNTER;
    end else if (countTick) begin
      if (periodMatch && (runMode == TESQ_RUN_MATCH_CLR)) begin
        next_counter = RST_COUNTER;
      end else begin
        next_counter = main_counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presc        <= PRESC_RST;
      halfPhase    <= 1'b0;
      main_counter <= RST_COUNTER;
    end else if (ce) begin
      presc        <= next_presc;
      halfPhase    <= next_halfPhase;
      main_counter <= next_counter;
    end
  end

  // ------------------------------------------------------------
  // Timer output and period interrupt
  // ------------------------------------------------------------
  // One-shot: active from pulse match until period match. Square wave:
  // invert on each period match. Output disabled forces the pin low.
  always_comb begin
    next_outLevel    = outLevel;
    next_pulseActive = pulseActive;
    next_periodIrq   = periodMatch;
    if (!running || !output_control_reg[TOC_OE_BIT]) begin
      next_outLevel    = 1'b0;
      next_pulseActive = running && pulseActive && !periodMatch;
    end else if (oneShotMode) begin
      if (clearStart) begin
        next_outLevel    = 1'b0;
        next_pulseActive = 1'b1;
      end else if (periodMatch) begin
        next_outLevel    = 1'b0;
        next_pulseActive = 1'b0;
      end else if (pulseMatch && pulseActive) begin
        next_outLevel = 1'b1;
      end
    end else if (toggleMode && periodMatch) begin
      next_outLevel = !outLevel;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outLevel    <= 1'b0;
      pulseActive <= 1'b0;
      periodIrq   <= 1'b0;
    end else if (ce) begin
      outLevel    <= next_outLevel;
      pulseActive <= next_pulseActive;
      periodIrq   <= next_periodIrq;
    end
  end

  assign timer_output_pin = outLevel;
  assign period_match_irq = periodIrq;

  // ------------------------------------------------------------
  // Capture into the pulse compare register
  // ------------------------------------------------------------
  // Edge waits for the next count clock to capture, flag follows one count
  // clock later; a register read in between does not block it
  always_comb begin
    next_capPending    = capPending;
    next_capIrqPending = capIrqPending;
    next_capIrq        = 1'b0;
    if (!running || !captureMode || clkSel == TESQ_CLK_EVENT) begin
      next_capPending    = 1'b0;
      next_capIrqPending = 1'b0;
    end else if (countTick) begin
      next_capPending    = 1'b0;
      next_capIrqPending = capPending || trig.validEdge;
      next_capIrq        = capIrqPending;
    end else if (trig.validEdge) begin
      next_capPending = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      capPending    <= 1'b0;
      capIrqPending <= 1'b0;
      capIrq        <= 1'b0;
    end else if (ce) begin
      capPending    <= next_capPending;
      capIrqPending <= next_capIrqPending;
      capIrq        <= next_capIrq;
    end
  end

  assign capture_pulse_irq = capIrq;
endmodule

// ==== tesq_timer_assertions.sv ====
// Concurrent checks on the timer's ports
`timescale 1ns/1ps
module tesq_timer_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        trigger_input_pin,
  input wire logic        timer_output_pin,
  input wire logic        period_match_irq,
  input wire logic        capture_pulse_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // -------------------------
  // Bus and output timing
  // -------------------------
  // Access still in its wait state, then answered
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> s_ans)
    else $error("access not answered after one wait state");
  AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no access");
  AST_RD_UPPER: assert property (s_ans and avs_read |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_PM_PULSE: assert property (period_match_irq |=> !period_match_irq)
    else $error("period match pulse longer than one cycle");
  AST_CAP_PULSE: assert property (capture_pulse_irq |=> !capture_pulse_irq)
    else $error("capture pulse longer than one cycle");
  AST_FALL_AT_MATCH: assert property ($fell(timer_output_pin) |-> period_match_irq)
    else $error("output fell away from a period match");
  AST_HIGH_HOLD: assert property ($rose(timer_output_pin) |-> timer_output_pin[*2])
    else $error("output high for a single cycle");
  AST_QUIET_RST: assert property ($fell(rst) |->
    !timer_output_pin && !period_match_irq && !capture_pulse_irq)
    else $error("output or interrupt active out of reset");
endmodule
bind tesq_timer tesq_timer_assertions u_tesq_timer_assertions (.sys_clk(sys_clk), .rst(rst),
  .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .trigger_input_pin(trigger_input_pin), .timer_output_pin(timer_output_pin),
  .period_match_irq(period_match_irq), .capture_pulse_irq(capture_pulse_irq));

// ==== tesq_timer_tb.sv ====
// Self-checking bench driving the timer over its register bus
`timescale 1ns/1ps
module tesq_timer_tb;
  import tesq_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        ce;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigPin;
  logic        outPin;
  logic        pmIrq;
  logic        capIrq;
  logic [15:0] c0;
  logic [15:0] c1;
  logic [7:0]  edgeCode [4] = '{8'h03, 8'h13, 8'h23, 8'h33};
  logic [15:0] edgeCount [4] = '{16'h0001, 16'h0001, 16'h0000, 16'h0002};
  int          errors;
  int          testsRun;
  time         t0;
  tesq_timer u_tesq_timer (.sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_input_pin(trigPin),
    .timer_output_pin(outPin), .period_match_irq(pmIrq), .capture_pulse_irq(capIrq));
  tesq_trig_src u_tesq_trig_src (.sys_clk(sys_clk), .pin(trigPin));
  // -------------
  // Helper tasks
  // -------------
  task automatic finish_test();
    if (errors == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bail();
    errors++;
    finish_test();
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Request stays up until waitrequest is seen low at an edge
  task automatic hold_bus();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) bail();
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= 1'b1;
    hold_bus();
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    hold_bus();
    d = avs_readdata[15:0];
    avs_read <= 1'b0;
  endtask
  function automatic logic sg(input int s);
    return (s == 0) ? outPin : (s == 1) ? pmIrq : capIrq;
  endfunction
  // Bounded wait for a level on output, period or capture line
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (sg(s) !== v) begin
      @(posedge sys_clk);
      n++;
      if (n > 4000) bail();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ---------------
  // Main sequence
  // ---------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h3;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_PERIOD_COMPARE, c0);
    chk(c0, RST_PERIOD);
    rd(5'h02, c0);
    chk(c0, RDATA_UNMAP[15:0]);
    // Event counting: a glitch is dropped, the second edge matches
    wr(OFF_PERIOD_COMPARE, 16'h0001);
    wr(OFF_PRESCALER_MODE, 16'h0013);
    wr(OFF_TIMER_MODE, 16'h000c);
    u_tesq_trig_src.drive(1'b1, 0);
    u_tesq_trig_src.drive(1'b0, 12);
    rd(OFF_MAIN_COUNTER, c0);
    chk(c0, 16'h0000);
    u_tesq_trig_src.drive(1'b1, 10);
    u_tesq_trig_src.drive(1'b0, 10);
    rd(OFF_MAIN_COUNTER, c0);
    chk(c0, 16'h0001);
    u_tesq_trig_src.drive(1'b1, 0);
    wt(1, 1'b1);
    u_tesq_trig_src.drive(1'b0, 10);
    rd(OFF_MAIN_COUNTER, c0);
    chk(c0, 16'h0000);
    // Every edge code, changed only while stopped
    wr(OFF_PERIOD_COMPARE, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_TIMER_MODE, 16'h0000);
      wr(OFF_PRESCALER_MODE, {8'h00, edgeCode[k]});
      wr(OFF_TIMER_MODE, 16'h000c);
      rd(OFF_MAIN_COUNTER, c0);
      u_tesq_trig_src.drive(1'b1, 10);
      u_tesq_trig_src.drive(1'b0, 10);
      rd(OFF_MAIN_COUNTER, c1);
      chk(c1 - c0, edgeCount[k]);
    end
    // Software one-shot at half the base clock
    wr(OFF_TIMER_MODE, 16'h0000);
    wr(OFF_PRESCALER_MODE, 16'h0000);
    wr(OFF_PULSE_COMPARE, 16'h0004);
    wr(OFF_PERIOD_COMPARE, 16'h000a);
    wr(OFF_OUTPUT_CONTROL, 16'h0011);
    wr(OFF_TIMER_MODE, 16'h0004);
    chk({15'h0000, outPin}, 16'h0000);
    wr(OFF_OUTPUT_CONTROL, 16'h0051);
    t0 = $time;
    wt(0, 1'b1);
    chk({15'h0000, ($time - t0) >= 150 && ($time - t0) <= 300}, 16'h0001);
    t0 = $time;
    wt(0, 1'b0);
    chk({15'h0000, pmIrq}, 16'h0001);
    chk(16'(($time - t0) / 25), 16'h000c);
    rd(OFF_MAIN_COUNTER, c0);
    rd(OFF_MAIN_COUNTER, c1);
    chk({15'h0000, c1 > c0}, 16'h0001);
    wr(OFF_TIMER_MODE, 16'h0000);
    rd(OFF_MAIN_COUNTER, c0);
    rd(OFF_MAIN_COUNTER, c1);
    chk(c1 - c0, 16'h0000);
    // External one-shot; a second edge inside the pulse is ignored
    wr(OFF_PULSE_COMPARE, 16'h0014);
    wr(OFF_PERIOD_COMPARE, 16'h003c);
    wr(OFF_PRESCALER_MODE, 16'h0010);
    wr(OFF_TIMER_MODE, 16'h0008);
    u_tesq_trig_src.drive(1'b1, 10);
    u_tesq_trig_src.drive(1'b0, 0);
    wt(0, 1'b1);
    t0 = $time;
    u_tesq_trig_src.drive(1'b1, 10);
    u_tesq_trig_src.drive(1'b0, 10);
    wt(0, 1'b0);
    chk(16'(($time - t0) / 25), 16'h0050);
    // Capture on a free-running count
    wr(OFF_TIMER_MODE, 16'h0000);
    wr(OFF_CAPTURE_CTRL, 16'h0001);
    wr(OFF_TIMER_MODE, 16'h0004);
    u_tesq_trig_src.drive(1'b1, 0);
    wt(2, 1'b1);
    u_tesq_trig_src.drive(1'b0, 10);
    // Square wave; the trigger write clears a stale count first
    wr(OFF_TIMER_MODE, 16'h0000);
    wr(OFF_PERIOD_COMPARE, 16'h0005);
    wr(OFF_TIMER_MODE, 16'h000c);
    wr(OFF_OUTPUT_CONTROL, 16'h0043);
    wt(0, 1'b1);
    t0 = $time;
    wt(0, 1'b0);
    chk(16'(($time - t0) / 25), 16'h000c);
    finish_test();
  end
endmodule

// ==== tesq_trig_filter.sv ====
// Trigger input synchroniser, noise filter and valid edge detector
`timescale 1ns/1ps
module tesq_trig_filter (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic trigIn,
  tesq_trig_if.filt trig
);
  import tesq_pkg::*;

  logic syncA;
  logic syncB;
  logic syncC;
  logic level;
  logic edgeOut;
  logic next_level;
  logic next_edgeOut;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // A new level counts only when two successive samples agree
  always_comb begin
    next_level   = level;
    next_edgeOut = 1'b0;
    if (trig.sampleEn && (syncB == syncC) && (syncC != level)) begin
      next_level = syncC;
      unique case (trig.edgeSel)
        TESQ_EDGE_RISE: next_edgeOut = syncC;
        TESQ_EDGE_FALL: next_edgeOut = !syncC;
        TESQ_EDGE_BOTH: next_edgeOut = 1'b1;
        TESQ_EDGE_NONE: next_edgeOut = 1'b0;
      endcase
      next_edgeOut = next_edgeOut && trig.accept;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Chain advances at the sample rate; the level starts low and follows a high pin
  // after reset even while stopped, with that edge masked because accept is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncA   <= 1'b0;
      syncB   <= 1'b0;
      syncC   <= 1'b0;
      level   <= 1'b0;
      edgeOut <= 1'b0;
    end else if (ce) begin
      if (trig.sampleEn) begin
        syncA <= trigIn;
        syncB <= syncA;
        syncC <= syncB;
      end
      level   <= next_level;
      edgeOut <= next_edgeOut;
    end
  end

  assign trig.level     = level;
  assign trig.validEdge = edgeOut && ce;
endmodule

// ==== tesq_trig_if.sv ====
// Carrier between the timer core and the trigger input filter
`timescale 1ns/1ps
interface tesq_trig_if;
  import tesq_pkg::*;
  tesq_edge_t edgeSel;    // Valid edge selection
  logic       sampleEn;   // Sample strobe at half the base clock
  logic       accept;     // Edges accepted only while running
  logic       validEdge;  // One-cycle pulse per valid edge
  logic       level;      // Filtered pin level

  modport core (output edgeSel, output sampleEn, output accept,
                input validEdge, input level);
  modport filt (input edgeSel, input sampleEn, input accept,
                output validEdge, output level);
endinterface

// ==== tesq_trig_src.sv ====
// Trigger source model that drives the timer's trigger pin
`timescale 1ns/1ps
module tesq_trig_src (
  input  wire logic sys_clk,
  output logic      pin
);
  // ----------
  // Pin driver
  // ----------
  // Starts low so the filter sees no stray edge after reset
  initial pin = 1'b0;
  // New level just after an edge, then held for w cycles
  task automatic drive(input logic v, input int w);
    @(posedge sys_clk);
    pin <= v;
    repeat (w) @(posedge sys_clk);
  endtask
endmodule
